// file: hw/lskm_pkg.sv
// package for the lvds skew probe multiplexer
// assumes a register write port inside the serial configuration block
package lskm_pkg;
  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h18;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam int         SEL_BIT       = 0;
  localparam int         ADDR_LSB      = 1;
  localparam int         ADDR_MSB      = 5;
  localparam int         EN_BIT        = 6;
  // ************************************************************
  // address landmarks
  // ************************************************************
  localparam logic [4:0] ADDR_CLOCK    = 5'h0f;
  localparam logic [4:0] ADDR_B_TOP    = 5'h10;
  localparam logic [4:0] ADDR_B_FIRST  = 5'h11;
  localparam int         PORT_W        = 16;
endpackage

// file: hw/lskm_probe_mux.sv
// lvds skew probe multiplexer: control register and signal selection
// assumes register writes arrive as a one-cycle strobe synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// probe multiplexer
// ************************************************************
// Function
// R1: the control register holds select at bit 0, address at bits 5:1, enable at bit 6.
// R2: a signal reaches the test output only while enable is set; the address picks the pair.
// R3: select 0 gives the first signal as is, select 1 the second signal inverted.
// R4: software keeps the temperature diode disabled while the probe is enabled.
// R5: address 0 gives port A bit top-1, or port A top bit inverted.
// R6: addresses 1 to 14 step port A down one bit each, paired with the bit above inverted.
// R7: address 15 gives the data clock, or port A bit 0 inverted on the widest variant.
// R8: address 16 gives port B top bit, or the data clock inverted.
// R9: addresses 17 to 31 step port B down, ending at bit 0 with bit 1 inverted.
// R10: narrower variants shift the map down; addresses past the port select nothing.
// R11: the control register resets to zero.
// R12: software compares only the two signals of one address and like edges.
// R13: software keeps the probe disabled in normal operation.
// R14: unused combinations leave the test output undriven while writes still store.
module lskm_probe_mux #(
  parameter int DATA_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              reg_wr_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wr_data,
  output logic      [7:0]        reg_rd_data,
  input  wire logic [DATA_W-1:0] port_a_lvds_bus,
  input  wire logic [DATA_W-1:0] port_b_lvds_bus,
  input  wire logic              lvds_data_clock_in,
  output logic                   test_output_pair,
  output logic                   test_output_oe
);

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic       ctrl_hit;
  logic       probe_pair_select;
  logic [4:0] probe_pair_address;
  logic       probe_mux_enable;

  // register write decode
  assign ctrl_hit  = reg_wr_en && (reg_addr == lskm_pkg::CTRL_OFFSET);
  assign ctrl_next = ctrl_hit ? {1'b0, reg_wr_data[6:0]} : ctrl_reg;  // R14

  // control register; bit 7 has no function and reads zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= lskm_pkg::CTRL_RESET;  // R11
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // field extraction
  assign probe_pair_select  = ctrl_reg[lskm_pkg::SEL_BIT];                        // R1
  assign probe_pair_address = ctrl_reg[lskm_pkg::ADDR_MSB:lskm_pkg::ADDR_LSB];    // R1
  assign probe_mux_enable   = ctrl_reg[lskm_pkg::EN_BIT];                          // R1
  assign reg_rd_data        = (reg_addr == lskm_pkg::CTRL_OFFSET) ? ctrl_reg : 8'h00;

  // ************************************************************
  // selection
  // ************************************************************
  // first signal index for a port step: address offset from port top
  function automatic logic [5:0] first_idx(input logic [4:0] step);
    first_idx = 6'(DATA_W - 2) - {1'b0, step};
  endfunction

  logic [4:0] step_a;
  logic [4:0] step_b;
  logic [5:0] idx_a;
  logic [5:0] idx_b;
  logic       in_a;
  logic       in_b;
  logic       sel_valid;
  logic       sel_value;

  // port A covers 0..14, port B 17..31 (step 0 means top-1 with top inverted)
  assign in_a   = (probe_pair_address < lskm_pkg::ADDR_CLOCK);
  assign in_b   = (probe_pair_address >= lskm_pkg::ADDR_B_FIRST);
  assign step_a = probe_pair_address;
  assign step_b = probe_pair_address - lskm_pkg::ADDR_B_FIRST;
  assign idx_a  = first_idx(step_a);                                              // R5 R6 R10
  assign idx_b  = first_idx(step_b);                                              // R9 R10

  // selection; a negative first index wraps high so the range checks fail
  always_comb begin
    sel_valid = 1'b0;
    sel_value = 1'b0;
    if (in_a) begin
      if (!probe_pair_select && idx_a < 6'(DATA_W)) begin                         // R3 R10
        sel_valid = 1'b1;
        sel_value = port_a_lvds_bus[idx_a[3:0]];
      end else if (probe_pair_select && (idx_a + 6'h01) < 6'(DATA_W)) begin     // R3 R10
        sel_valid = 1'b1;
        sel_value = ~port_a_lvds_bus[4'(idx_a + 6'h01)];
      end
    end else if (probe_pair_address == lskm_pkg::ADDR_CLOCK) begin
      if (!probe_pair_select) begin                                                 // R7
        sel_valid = 1'b1;
        sel_value = lvds_data_clock_in;
      end else if (DATA_W == lskm_pkg::PORT_W) begin                              // R7
        sel_valid = 1'b1;
        sel_value = ~port_a_lvds_bus[0];
      end
    end else if (probe_pair_address == lskm_pkg::ADDR_B_TOP) begin
      sel_valid = 1'b1;                                                             // R8
      sel_value = probe_pair_select ? ~lvds_data_clock_in : port_b_lvds_bus[DATA_W-1];
    end else if (in_b) begin
      if (!probe_pair_select && idx_b < 6'(DATA_W)) begin                         // R9 R10
        sel_valid = 1'b1;
        sel_value = port_b_lvds_bus[idx_b[3:0]];
      end else if (probe_pair_select && (idx_b + 6'h01) < 6'(DATA_W)) begin
        sel_valid = 1'b1;
        sel_value = ~port_b_lvds_bus[4'(idx_b + 6'h01)];
      end
    end
  end

  // output stage is combinational: the probe must follow edge timing, not the clock
  assign test_output_oe   = probe_mux_enable && sel_valid;                         // R2 R14
  assign test_output_pair = test_output_oe ? sel_value : 1'b0;                     // R2

  // ************************************************************
  // check helpers
  // ************************************************************
  // map end points worked out from the width alone, kept apart from first_idx
  // so that a slip in the selection arithmetic shows here instead of being copied
  // the inverted end point of port B falls past the field on the widest variant
  localparam int A_ZERO_SEL0 = DATA_W - 2;   // port A bit 0, first signal
  localparam int A_ZERO_SEL1 = DATA_W - 1;   // port A bit 0 inverted
  localparam int B_ZERO_SEL0 = DATA_W + 15;  // port B bit 0, first signal
  localparam int B_ZERO_SEL1 = DATA_W + 16;  // port B bit 0 inverted

  logic [5:0] chk_addr;
  logic       chk_plain;
  logic       chk_inv;

  // enable qualified views of the stored setting
  assign chk_addr  = {1'b0, probe_pair_address};
  assign chk_plain = probe_mux_enable && !probe_pair_select;
  assign chk_inv   = probe_mux_enable && probe_pair_select;

  // ************************************************************
  // checks
  // ************************************************************
  a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    !probe_mux_enable |-> !test_output_oe && !test_output_pair) else $error("probe driven while disabled");
  a_write_stores: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    ctrl_hit |=> ctrl_reg[6:0] == $past(reg_wr_data[6:0])) else $error("write not stored");
  a_clock_pick: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    (probe_mux_enable && probe_pair_address == 5'h0f && !probe_pair_select)
      |-> test_output_pair == lvds_data_clock_in) else $error("clock address wrong");
  a_clock_inv: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
    (probe_mux_enable && probe_pair_address == 5'h10 && probe_pair_select)
      |-> test_output_oe && test_output_pair == !lvds_data_clock_in) else $error("inverted clock wrong");
  a_b_top: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
    (probe_mux_enable && probe_pair_address == 5'h10 && !probe_pair_select)
      |-> test_output_pair == port_b_lvds_bus[DATA_W-1]) else $error("port b top wrong");
  a_a_top_inv: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    (probe_mux_enable && probe_pair_address == 5'h00 && probe_pair_select)
      |-> test_output_pair == !port_a_lvds_bus[DATA_W-1]) else $error("port a top wrong");
  a_b_last: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    (DATA_W == 16 && probe_mux_enable && probe_pair_address == 5'h1f && probe_pair_select)
      |-> test_output_pair == !port_b_lvds_bus[1]) else $error("port b last wrong");
  a_a_step: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    (DATA_W == 16 && probe_mux_enable && probe_pair_address == 5'h09 && !probe_pair_select)
      |-> test_output_pair == port_a_lvds_bus[5]) else $error("port a step wrong");
  a_reset_zero: assert property (@(posedge ref_clk) // R11
    $rose(rst_n) |-> ctrl_reg == 8'h00 || $past(ctrl_hit)) else $error("reset value wrong");

  // ************************************************************
  // register checks
  // ************************************************************

  // bit 7 has no storage, so a write of ones must never show there
  a_bit7_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    !ctrl_reg[7])
    else $error("unused bit set");

  // writes to any other address leave the setting alone
  a_foreign_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    (reg_wr_en && reg_addr != lskm_pkg::CTRL_OFFSET) |=> $stable(ctrl_reg))
    else $error("foreign write stored");

  // without a strobe the setting holds, so the probe never drifts mid-measurement
  a_idle_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    !reg_wr_en |=> $stable(ctrl_reg))
    else $error("setting drifted");

  // other addresses read as zero
  a_read_other: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    reg_addr != lskm_pkg::CTRL_OFFSET |-> reg_rd_data == 8'h00)
    else $error("other address reads nonzero");

  // the control address reads the stored setting
  a_read_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    reg_addr == lskm_pkg::CTRL_OFFSET |-> reg_rd_data == ctrl_reg)
    else $error("control readback wrong");

  // ************************************************************
  // map checks
  // ************************************************************

  // first row of port A
  a_a_first: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    (chk_plain && chk_addr == 6'h00) |-> test_output_oe && test_output_pair == port_a_lvds_bus[DATA_W-2])
    else $error("port a first wrong");

  // one step down port A, inverted side
  a_a_next_inv: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    (chk_inv && chk_addr == 6'h01) |-> test_output_oe && test_output_pair == !port_a_lvds_bus[DATA_W-2])
    else $error("port a step inverted wrong");

  // middle of the port A staircase
  a_a_mid: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    (chk_plain && chk_addr == 6'h05) |-> test_output_oe && test_output_pair == port_a_lvds_bus[DATA_W-7])
    else $error("port a middle wrong");

  // port A bit 0 as first signal, on every variant
  a_a_zero_plain: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    (chk_plain && int'(chk_addr) == A_ZERO_SEL0) |-> test_output_oe && test_output_pair == port_a_lvds_bus[0])
    else $error("port a bit 0 wrong");

  // port A bit 0 inverted; on the widest variant this shares the clock address
  a_a_zero_inv: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    (chk_inv && int'(chk_addr) == A_ZERO_SEL1) |-> test_output_oe && test_output_pair == !port_a_lvds_bus[0])
    else $error("port a bit 0 inverted wrong");

  // addresses below the clock but past port A bit 0 route nothing
  a_a_past_end: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    (probe_mux_enable && chk_addr < 6'h0f && int'(chk_addr) > A_ZERO_SEL1) |-> !test_output_oe)
    else $error("port a past end driven");

  // the inverted half of the clock address exists only on the widest variant
  a_clock_gap: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    (DATA_W != lskm_pkg::PORT_W && chk_inv && chk_addr == 6'h0f) |-> !test_output_oe)
    else $error("clock gap driven");

  // the clock address drives its first signal
  a_clock_plain_oe: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    (chk_plain && chk_addr == 6'h0f) |-> test_output_oe)
    else $error("clock address not driven");

  // first row of port B
  a_b_first: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    (chk_plain && chk_addr == 6'h11) |-> test_output_oe && test_output_pair == port_b_lvds_bus[DATA_W-2])
    else $error("port b first wrong");

  // first row of port B, inverted side
  a_b_first_inv: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    (chk_inv && chk_addr == 6'h11) |-> test_output_oe && test_output_pair == !port_b_lvds_bus[DATA_W-1])
    else $error("port b first inverted wrong");

  // port B bit 0 as first signal
  a_b_zero_plain: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    (chk_plain && int'(chk_addr) == B_ZERO_SEL0) |-> test_output_oe && test_output_pair == port_b_lvds_bus[0])
    else $error("port b bit 0 wrong");

  // port B bit 0 inverted, reachable only on narrower variants
  a_b_zero_inv: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    (chk_inv && int'(chk_addr) == B_ZERO_SEL1) |-> test_output_oe && test_output_pair == !port_b_lvds_bus[0])
    else $error("port b bit 0 inverted wrong");

  // addresses past port B bit 0 route nothing
  a_b_past_end: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    (probe_mux_enable && int'(chk_addr) > B_ZERO_SEL1) |-> !test_output_oe)
    else $error("port b past end driven");

  // ************************************************************
  // output checks
  // ************************************************************

  // an undriven output rests low so a stale level cannot be mistaken for a signal
  a_quiet_level: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    !test_output_oe |-> !test_output_pair)
    else $error("undriven output not low");

  // an enabled pair at address 16 is driven
  a_enable_drives: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    (probe_mux_enable && chk_addr == 6'h10) |-> test_output_oe)
    else $error("enabled probe not driven");

  // main scenarios; the bench reaches all but c_unused on the 16-bit variant

  c_enable: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(test_output_oe));
  c_clock: cover property (@(posedge ref_clk) disable iff (!rst_n)
    probe_mux_enable && probe_pair_address == 5'h10);
  c_unused: cover property (@(posedge ref_clk) disable iff (!rst_n)
    probe_mux_enable && !sel_valid);
  c_inverted: cover property (@(posedge ref_clk) disable iff (!rst_n)
    chk_inv && test_output_oe);
  c_a_bottom: cover property (@(posedge ref_clk) disable iff (!rst_n)
    chk_plain && int'(chk_addr) == A_ZERO_SEL0);

endmodule
`default_nettype wire

// file: verification/lskm_lvds_source.sv
// far-side lvds source feeding both data ports and the data clock
// assumes a free-running ref_clk; inputs move 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module lskm_lvds_source #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  output logic     [W-1:0]  port_a,
  output logic     [W-1:0]  port_b,
  output logic              data_clock
);
  // *******************
  // scrambled count, so neighbouring bits differ and a swapped pair shows
  // *******************
  logic [15:0] cnt;
  initial cnt = 16'h0000;
  always @(posedge ref_clk) cnt <= #1 cnt + 16'h0001;
  assign port_a     = W'(cnt * 16'h9e37);
  assign port_b     = W'(cnt * 16'h7f4b + 16'h1234);
  assign data_clock = cnt[0];
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// bench for the skew probe mux: map sweep, enable, refusal, reset
// assumes the default 16-bit variant; the temp diode never comes on here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int W = 16;
  logic         ref_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         reg_wr_en = 1'b0;
  logic [7:0]   reg_addr = 8'h18;
  logic [7:0]   reg_wr_data = 8'h00;
  logic [7:0]   reg_rd_data;
  logic [W-1:0] port_a, port_b;
  logic         clk_in, test_output_pair, test_output_oe;
  int           miscompares = 0;
  int           total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  lskm_lvds_source #(.W(W)) SRC (.ref_clk(ref_clk), .port_a(port_a), .port_b(port_b), .data_clock(clk_in));
  lskm_probe_mux #(.DATA_W(W)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .port_a_lvds_bus(port_a),
    .port_b_lvds_bus(port_b), .lvds_data_clock_in(clk_in), .test_output_pair(test_output_pair),
    .test_output_oe(test_output_oe));
  // *******************
  // expected {oe, level}; unused combinations fall out as a bit index off the port
  // *******************
  function automatic logic [1:0] exp_out(input logic [7:0] c);
    int a, i;
    a = int'(c[5:1]);
    i = (a < 16) ? W - 2 - a + int'(c[0]) : W - 1 - (a - 16) + int'(c[0]);
    if (!c[6]) return 2'b00;
    if (a == 15 && !c[0]) return {1'b1, clk_in};
    if (a == 16 && c[0]) return {1'b1, ~clk_in};
    if (i < 0 || i >= W) return 2'b00;
    if (a < 16) return {1'b1, port_a[i] ^ c[0]};
    return {1'b1, port_b[i] ^ c[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
  endtask
  // four cycles each, sampled mid-cycle when the source has settled; one address per call
  task automatic probe(input logic [7:0] c);
    repeat (4) begin
      #3;
      check({6'h00, test_output_oe, test_output_pair}, {6'h00, exp_out(c)}, "probe");
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic sweep_map();
    for (int k = 0; k < 64; k++) begin
      wr(8'h18, 8'h40 | 8'(k));
      check(reg_rd_data, 8'h40 | 8'(k), "readback");
      probe(8'h40 | 8'(k));
    end
  endtask
  task automatic disabled_and_refused();
    wr(8'h18, 8'h21);
    check(reg_rd_data, 8'h21, "stored while off");
    probe(8'h21);
    wr(8'h18, 8'hff);
    check(reg_rd_data, 8'h7f, "top bit");
    @(posedge ref_clk);
    #1;
    wr(8'h19, 8'h00);
    check(reg_rd_data, 8'h00, "other address");
    reg_addr = 8'h18;
    #1;
    check(reg_rd_data, 8'h7f, "kept");
  endtask
  task automatic reset_state();
    reg_addr = 8'h18;
    #1;
    check(reg_rd_data, lskm_pkg::CTRL_RESET, "reset value");
    probe(8'h00);
  endtask
  // second release: the first write, 0x60, lands on the first edge, then 0x61
  task automatic release_walk();
    wr(8'h18, 8'h60);
    check(reg_rd_data, 8'h60, "write after release");
    probe(8'h60);
    wr(8'h18, 8'h61);
    probe(8'h61);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // no diode enable exists here, and the mux is only on while measuring
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    reset_state();
    sweep_map();
    disabled_and_refused();
    rst_n = 1'b0;
    reset_state();
    rst_n = 1'b1;
    release_walk();
    give_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
